// File: core_model.sv
`default_nettype none
module core_model (
  input  wire logic CLK,
  input  wire logic RESET,
  input  wire logic IRQ_REQ,
  input  wire logic hold,
  input  wire logic slow,
  output var  logic IRQ_ACK,
  output var  logic RETURN_PULSE
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wt;
  logic [3:0] svc;
  logic [3:0] depth;
  // Takes a request, services it, then returns
  always @(posedge CLK) begin
    IRQ_ACK <= 1'b0;
    RETURN_PULSE <= 1'b0;
    if (RESET) begin
      wt <= 4'h0;
      svc <= 4'h0;
      depth <= 4'h0;
    end else if (IRQ_REQ && !hold && !IRQ_ACK && !RETURN_PULSE) begin
      if (slow && wt < 4'h5) begin
        wt <= wt + 4'h1;
      end else begin
        IRQ_ACK <= 1'b1;
        wt <= 4'h0;
        depth <= depth + 4'h1;
        svc <= 4'h6;
      end
    end else if (depth != 4'h0 && !IRQ_ACK) begin
      if (svc != 4'h0) begin
        svc <= svc - 4'h1;
      end else begin
        RETURN_PULSE <= 1'b1;
        depth <= depth - 4'h1;
        svc <= 4'h6;
      end
    end
  end
endmodule
`default_nettype wire

// File: interrupt_priority_and_vector_status_bench.sv
`default_nettype none
module interrupt_priority_and_vector_status_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CLK, RESET, WR, RD, IRQ_ACK, RETURN_PULSE, DELAYED_DISABLE_INSTR_START, IRQ_REQ, IRQ, hold, slow;
  logic [3:0]  ADDR, IRQ_LEVEL, CPU_LEVEL;
  logic [15:0] WDATA, RDATA, d;
  logic [9:0]  SRC_FLAG, SRC_ENABLE;
  logic [7:0]  TRAP_FLAG;
  logic [13:0] DELAYED_DISABLE_INSTR_CYCLES;
  logic [6:0]  IRQ_VECTOR;
  logic [31:0] seed = 32'h000067B8;
  int          num_errors = 0, tests_run = 0, acks;
  intprio_ctrl u_intprio_ctrl (.CLK, .RESET, .ADDR, .WDATA, .WR, .RD, .RDATA, .SRC_FLAG,
    .SRC_ENABLE, .TRAP_FLAG, .IRQ_ACK, .RETURN_PULSE, .DELAYED_DISABLE_INSTR_START, .DELAYED_DISABLE_INSTR_CYCLES, .IRQ_REQ,
    .IRQ_VECTOR, .IRQ_LEVEL, .CPU_LEVEL, .IRQ);
  core_model u_core_model (.CLK, .RESET, .IRQ_REQ, .hold, .slow, .IRQ_ACK, .RETURN_PULSE);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [15:0] fmask(input int i);
    return (i == 0) ? 16'h7007 : (i == 1) ? 16'h0077 : (i == 2) ? 16'h0770 : 16'h7777;
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge CLK) begin ADDR <= a; WDATA <= v; WR <= 1'b1; end
    @(posedge CLK) WR <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge CLK) begin ADDR <= a; RD <= 1'b1; end
    @(posedge CLK) RD <= 1'b0;
    #1 d = RDATA;
  endtask
  task automatic fl(input logic [9:0] f, input logic [9:0] e, input logic [7:0] t);
    @(posedge CLK) begin SRC_FLAG <= f; SRC_ENABLE <= e; TRAP_FLAG <= t; end
  endtask
  task automatic req(input logic [15:0] e);
    cyc(4);
    chk(IRQ_REQ ? {IRQ_REQ, 4'h0, IRQ_LEVEL, IRQ_VECTOR} : 16'h0000, e);
  endtask
  task automatic count_acks(input int n);
    acks = 0;
    repeat (n) begin cyc(1); acks += IRQ_ACK; end
  endtask
  task automatic stop_test;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end
  initial begin
    #200000;
    num_errors++;
    stop_test;
  end
  initial begin
    {RESET, hold} = 2'h3;
    {WR, RD, DELAYED_DISABLE_INSTR_START, slow, ADDR, WDATA, SRC_FLAG, SRC_ENABLE, TRAP_FLAG, DELAYED_DISABLE_INSTR_CYCLES} = '0;
    repeat (20) @(posedge CLK);
    RESET <= 1'b0;
    for (int i = 0; i < 4; i++) begin rd(i[3:0]); chk(d, 16'h4444 & fmask(i)); end
    rd(4'hF); chk(d, 16'h0000);
    for (int i = 0; i < 16; i++) begin
      seed = xs(seed);
      wr({2'h0, i[1:0]}, seed[15:0]);
      rd({2'h0, i[1:0]}); chk(d, seed[15:0] & fmask(i % 4));
    end
    wr(4'h0, 16'h0005); wr(4'h1, 16'h0055); wr(4'h2, 16'h0300); wr(4'h3, 16'h7123);
    fl(10'h3FF, 10'h3BF, 8'h00); req(16'h8289);
    rd(4'h4); chk(d, 16'h0501);
    fl(10'h061, 10'h3BF, 8'h00); req(16'h0000);
    fl(10'h000, 10'h3FF, 8'h00); wr(4'h6, 16'h00E0);
    fl(10'h040, 10'h3FF, 8'h00); req(16'h0000);
    fl(10'h040, 10'h3FF, 8'h04); req(16'h8502);
    rd(4'h4); chk(d, 16'h0A02);
    hold <= 1'b0;
    count_acks(40); chk(16'(acks >= 2), 16'h0001);
    fl(10'h000, 10'h3FF, 8'h00); cyc(30);
    hold <= 1'b1;
    wr(4'h6, 16'h0000); fl(10'h010, 10'h3FF, 8'h00);
    {hold, slow} <= 2'h1;
    count_acks(80); chk(16'(acks >= 2), 16'h0001);
    {hold, slow} <= 2'h2;
    cyc(40); chk(16'(CPU_LEVEL), 16'h0000);
    fl(10'h000, 10'h3FF, 8'h00);
    wr(4'h5, 16'h8000); rd(4'h7); hold <= 1'b0;
    fl(10'h010, 10'h3FF, 8'h00);
    do cyc(1); while (!IRQ_ACK);
    fl(10'h050, 10'h3FF, 8'h00); cyc(40);
    hold <= 1'b1;
    fl(10'h000, 10'h3FF, 8'h00); cyc(30);
    rd(4'h7); chk(16'(d[3]), 16'h0000);
    wr(4'h5, 16'h0000);
    seed = xs(seed);
    @(posedge CLK) begin DELAYED_DISABLE_INSTR_START <= 1'b1; DELAYED_DISABLE_INSTR_CYCLES <= 14'h0028 + 14'(seed[3:0]); end
    @(posedge CLK) DELAYED_DISABLE_INSTR_START <= 1'b0;
    fl(10'h010, 10'h3FF, 8'h00); cyc(8); req(16'h0000);
    fl(10'h050, 10'h3FF, 8'h00); req(16'h838E);
    fl(10'h010, 10'h3FF, 8'h00); cyc(60); req(16'h818C);
    fl(10'h000, 10'h3FF, 8'h00); wr(4'h8, 16'h0000); rd(4'h7);
    fl(10'h000, 10'h3FF, 8'h01); cyc(4); chk(16'(IRQ), 16'h0000);
    wr(4'h8, 16'h0002); cyc(3); chk(16'(IRQ), 16'h0001);
    rd(4'h7); chk(d, 16'h0002);
    cyc(3); chk(16'(IRQ), 16'h0000);
    fl(10'h000, 10'h3FF, 8'h00); cyc(5);
    stop_test;
  end
endmodule
bind intprio_ctrl intprio_ctrl_assertions u_intprio_ctrl_assertions (.CLK, .RESET, .ADDR,
  .WDATA, .WR, .RD, .RDATA, .SRC_FLAG, .SRC_ENABLE, .TRAP_FLAG, .IRQ_ACK, .RETURN_PULSE,
  .DELAYED_DISABLE_INSTR_START, .DELAYED_DISABLE_INSTR_CYCLES, .IRQ_REQ, .IRQ_VECTOR, .IRQ_LEVEL, .CPU_LEVEL, .IRQ);
`default_nettype wire

// File: intprio_ctrl.v
// How it works
// - A three-bit field gives priority 1 to 7, and code 000 turns its source off.
// - Reset loads level 4 into every user priority field.
// - Fields sit at bits 14-12, 10-8, 6-4, 2-0; all other bits read zero, ignore writes.
// - Status bits 6-0 show a pending user vector number minus eight, or a pending trap vector unchanged.
// - With nesting disabled no new user interrupt preempts one in service.
// - A user source can request only while its enable bit is set.
// - A flag left set is requested again right after the return.
// - The return restores the saved status low byte and previous CPU level.
// - A trap flag left set is taken again after its handler returns.
// - CPU level 7 masks every user source.
// - Traps at levels 8 to 15 are delivered when above the CPU level, whatever the disables.
// - The delayed disable blocks levels 1 to 6 for a count of cycles, never level 7.
// - Several sources may share one non-zero priority and are still arbitrated.
`default_nettype none

module intprio_ctrl (
  input  wire        CLK,
  input  wire        RESET,
  input  wire [3:0]  ADDR,
  input  wire [15:0] WDATA,
  input  wire        WR,
  input  wire        RD,
  output reg  [15:0] RDATA,
  input  wire [9:0]  SRC_FLAG,
  input  wire [9:0]  SRC_ENABLE,
  input  wire [7:0]  TRAP_FLAG,
  input  wire        IRQ_ACK,
  input  wire        RETURN_PULSE,
  input  wire        DELAYED_DISABLE_INSTR_START,
  input  wire [13:0] DELAYED_DISABLE_INSTR_CYCLES,
  output reg         IRQ_REQ,
  output reg  [6:0]  IRQ_VECTOR,
  output reg  [3:0]  IRQ_LEVEL,
  output reg  [3:0]  CPU_LEVEL,
  output reg         IRQ
);

`include "intprio_defines.vh"

  // ----------------------------------------------------------------
  // Priority registers
  // ----------------------------------------------------------------
  wire [15:0] prio14;
  wire [15:0] prio15;
  wire [15:0] prio16;
  wire [15:0] prio17;
  wire        wr_prio14 = WR && (ADDR == `OFS_PRIO14);
  wire        wr_prio15 = WR && (ADDR == `OFS_PRIO15);
  wire        wr_prio16 = WR && (ADDR == `OFS_PRIO16);
  wire        wr_prio17 = WR && (ADDR == `OFS_PRIO17);

  prio_reg #(.FIELD_MASK(`MASK_PRIO14_FULL)) u_prio14 (
    .CLK   (CLK),
    .RESET (RESET),
    .wr    (wr_prio14),
    .wdata (WDATA),
    .q     (prio14)
  );

  prio_reg #(.FIELD_MASK(`MASK_PRIO15)) u_prio15 (
    .CLK   (CLK),
    .RESET (RESET),
    .wr    (wr_prio15),
    .wdata (WDATA),
    .q     (prio15)
  );

  prio_reg #(.FIELD_MASK(`MASK_PRIO16)) u_prio16 (
    .CLK   (CLK),
    .RESET (RESET),
    .wr    (wr_prio16),
    .wdata (WDATA),
    .q     (prio16)
  );

  prio_reg #(.FIELD_MASK(`MASK_PRIO17)) u_prio17 (
    .CLK   (CLK),
    .RESET (RESET),
    .wr    (wr_prio17),
    .wdata (WDATA),
    .q     (prio17)
  );

  // Source order gives vector order: index 0 is the lowest vector
  wire [2:0] codec_port_error_priority = prio14[14:12];
  wire [2:0] can_two_event_priority    = prio14[2:0];
  wire [2:0] xfer_chan5_done_priority  = prio15[6:4];
  wire [2:0] codec_port_event_priority = prio15[2:0];
  wire [2:0] serial_two_error_priority = prio16[10:8];
  wire [2:0] serial_one_error_priority = prio16[6:4];
  wire [2:0] can_two_transmit_priority = prio17[14:12];
  wire [2:0] can_one_transmit_priority = prio17[10:8];
  wire [2:0] xfer_chan7_done_priority  = prio17[6:4];
  wire [2:0] xfer_chan6_done_priority  = prio17[2:0];

  wire [29:0] src_prio = {xfer_chan6_done_priority, xfer_chan7_done_priority,
                          can_one_transmit_priority, can_two_transmit_priority,
                          serial_one_error_priority, serial_two_error_priority,
                          codec_port_event_priority, xfer_chan5_done_priority,
                          can_two_event_priority, codec_port_error_priority};

  // ----------------------------------------------------------------
  // Control, status low byte and level stack
  // ----------------------------------------------------------------
  reg        nesting_disable;
  reg [7:0]  status_low_byte;
  reg [3:0]  cur_level;
  reg [95:0] stack;
  reg [3:0]  depth;
  reg [13:0] delayed_disable_instr_count;
  reg [3:0]  event_status;
  reg [3:0]  event_mask;
  reg [3:0]  new_level;
  reg [6:0]  pend_vec;
  reg        pend_valid;
  reg        pend_trap;

  wire in_service  = (depth != 4'h0);
  wire delayed_disable_instr_active = (delayed_disable_instr_count != 14'h0000);

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  reg [3:0]  next_level;
  reg [6:0]  next_vec;
  reg        next_valid;
  reg        next_trap;
  reg [2:0]  p;
  reg        blocked;
  integer    i;

  always @* begin
    next_level = 4'h0;
    next_vec   = 7'h00;
    next_valid = 1'b0;
    next_trap  = 1'b0;
    p          = 3'h0;
    blocked    = 1'b0;
    for (i = 0; i < 10; i = i + 1) begin
      p = src_prio[3*i +: 3];
      blocked = (p == `PRIO_DISABLED);
      if (!SRC_ENABLE[i] || !SRC_FLAG[i]) begin
        blocked = 1'b1;
      end
      if ({1'b0, p} <= cur_level) begin
        blocked = 1'b1;
      end
      if (delayed_disable_instr_active && (p <= `PRIO_DELAYED_DISABLE_INSTR_MAX)) begin
        blocked = 1'b1;
      end
      if (nesting_disable && in_service) begin
        blocked = 1'b1;
      end
      // Strict compare keeps the lowest index among equals
      if (!blocked && (!next_valid || ({1'b0, p} > next_level))) begin
        next_valid = 1'b1;
        next_level = {1'b0, p};
        next_vec   = `USER_VEC_BASE + i[6:0];
      end
    end
    for (i = 0; i < 8; i = i + 1) begin
      if (TRAP_FLAG[i] && ((`TRAP_LEVEL_BASE + i[3:0]) > cur_level)) begin
        next_valid = 1'b1;
        next_trap  = 1'b1;
        next_level = `TRAP_LEVEL_BASE + i[3:0];
        next_vec   = i[6:0];
      end
    end
  end

  always @(posedge CLK) begin
    if (RESET) begin
      pend_valid <= 1'b0;
      pend_trap  <= 1'b0;
      new_level  <= 4'h0;
      pend_vec   <= 7'h00;
    end else begin
      pend_valid <= next_valid && !IRQ_ACK && !RETURN_PULSE;
      pend_trap  <= next_trap;
      new_level  <= next_level;
      pend_vec   <= next_vec;
    end
  end

  // ----------------------------------------------------------------
  // Level tracking, nesting and return
  // ----------------------------------------------------------------
  always @(posedge CLK) begin
    if (RESET) begin
      cur_level       <= 4'h0;
      status_low_byte <= 8'h00;
      stack           <= 96'h0;
      depth           <= 4'h0;
    end else if (IRQ_ACK && IRQ_REQ && (depth != `STACK_DEPTH)) begin
      // Push the old level, then enter the level the core was shown, not a later arbitration
      stack                       <= {stack[83:0], cur_level, status_low_byte};
      depth                       <= depth + 4'h1;
      cur_level                   <= IRQ_LEVEL;
      status_low_byte[`IPL_HI:`IPL_LO] <= IRQ_LEVEL[2:0];
    end else if (RETURN_PULSE && in_service) begin
      cur_level       <= stack[11:8];
      status_low_byte <= stack[7:0];
      stack           <= {12'h000, stack[95:12]};
      depth           <= depth - 4'h1;
    end else if (WR && (ADDR == `OFS_STATUS_LOW)) begin
      status_low_byte <= WDATA[7:0];
      if (cur_level < `TRAP_LEVEL_BASE) begin
        cur_level <= {1'b0, WDATA[`IPL_HI:`IPL_LO]};
      end
    end
  end

  // ----------------------------------------------------------------
  // Delayed disable counter and control register
  // ----------------------------------------------------------------
  always @(posedge CLK) begin
    if (RESET) begin
      delayed_disable_instr_count <= 14'h0000;
    end else if (DELAYED_DISABLE_INSTR_START) begin
      delayed_disable_instr_count <= DELAYED_DISABLE_INSTR_CYCLES;
    end else if (delayed_disable_instr_active) begin
      delayed_disable_instr_count <= delayed_disable_instr_count - 14'h0001;
    end
  end

  always @(posedge CLK) begin
    if (RESET) begin
      nesting_disable <= 1'b0;
      event_mask      <= 4'h0;
    end else if (WR && (ADDR == `OFS_CONTROL_ONE)) begin
      nesting_disable <= WDATA[`NEST_DIS_BIT];
    end else if (WR && (ADDR == `OFS_EVENT_MASK)) begin
      event_mask <= WDATA[3:0];
    end
  end

  // ----------------------------------------------------------------
  // Event status: set wins over the read clear
  // ----------------------------------------------------------------
  wire [3:0] ev_set = {IRQ_ACK && IRQ_REQ && in_service,
                       RETURN_PULSE && in_service,
                       next_valid && next_trap && !pend_valid,
                       next_valid && !next_trap && !pend_valid};
  wire       ev_read = RD && (ADDR == `OFS_EVENT_STATUS);
  wire [3:0] next_event_status = (ev_read ? 4'h0 : event_status) | ev_set;

  always @(posedge CLK) begin
    if (RESET) begin
      event_status <= 4'h0;
    end else begin
      event_status <= next_event_status;
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  reg [15:0] next_rdata;

  always @* begin
    case (ADDR)
      `OFS_PRIO14:       next_rdata = prio14;
      `OFS_PRIO15:       next_rdata = prio15;
      `OFS_PRIO16:       next_rdata = prio16;
      `OFS_PRIO17:       next_rdata = prio17;
      `OFS_PEND_STATUS:  next_rdata = {4'h0, new_level, 1'b0,
                                       pend_vec - `USER_VEC_BASE * {6'h00, !pend_trap}};
      `OFS_CONTROL_ONE:  next_rdata = {nesting_disable, 15'h0000};
      `OFS_STATUS_LOW:   next_rdata = {8'h00, status_low_byte};
      `OFS_EVENT_STATUS: next_rdata = {12'h000, event_status};
      `OFS_EVENT_MASK:   next_rdata = {12'h000, event_mask};
      default:           next_rdata = 16'h0000;
    endcase
  end

  always @(posedge CLK) begin
    if (RESET) begin
      RDATA      <= 16'h0000;
      IRQ_REQ    <= 1'b0;
      IRQ_VECTOR <= 7'h00;
      IRQ_LEVEL  <= 4'h0;
      CPU_LEVEL  <= 4'h0;
      IRQ        <= 1'b0;
    end else begin
      RDATA      <= RD ? next_rdata : 16'h0000;
      IRQ_REQ    <= pend_valid && !IRQ_ACK;
      IRQ_VECTOR <= pend_vec;
      IRQ_LEVEL  <= new_level;
      CPU_LEVEL  <= cur_level;
      IRQ        <= |(next_event_status & event_mask);
    end
  end

endmodule

`default_nettype wire

// File: intprio_ctrl_assertions.sv
`default_nettype none
module intprio_ctrl_assertions (
  input wire logic        CLK,
  input wire logic        RESET,
  input wire logic [3:0]  ADDR,
  input wire logic [15:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [15:0] RDATA,
  input wire logic [9:0]  SRC_FLAG,
  input wire logic [9:0]  SRC_ENABLE,
  input wire logic [7:0]  TRAP_FLAG,
  input wire logic        IRQ_ACK,
  input wire logic        RETURN_PULSE,
  input wire logic        DELAYED_DISABLE_INSTR_START,
  input wire logic [13:0] DELAYED_DISABLE_INSTR_CYCLES,
  input wire logic        IRQ_REQ,
  input wire logic [6:0]  IRQ_VECTOR,
  input wire logic [3:0]  IRQ_LEVEL,
  input wire logic [3:0]  CPU_LEVEL,
  input wire logic        IRQ
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  logic [13:0] dis_left;
  logic [1:0]  dis_age;
  // Cycles left and elapsed of a delayed disable
  always @(posedge CLK) begin
    if (RESET || DELAYED_DISABLE_INSTR_START) begin
      dis_left <= RESET ? 14'h0000 : DELAYED_DISABLE_INSTR_CYCLES;
      dis_age  <= 2'h0;
    end else begin
      dis_left <= (dis_left != 14'h0000) ? dis_left - 14'h0001 : dis_left;
      dis_age  <= (dis_age != 2'h3) ? dis_age + 2'h1 : dis_age;
    end
  end
  property p_rd_idle; !$past(RD) |-> RDATA == 16'h0000; endproperty
  property p_above; IRQ_REQ && IRQ_LEVEL < 4'h8 |-> IRQ_LEVEL > CPU_LEVEL && IRQ_LEVEL != 4'h0;
  endproperty
  property p_user_vec; IRQ_REQ && IRQ_LEVEL < 4'h8 |-> IRQ_VECTOR >= 7'h08 && IRQ_VECTOR <= 7'h11;
  endproperty
  property p_trap_vec; IRQ_REQ && IRQ_LEVEL >= 4'h8 |-> IRQ_VECTOR == 7'(IRQ_LEVEL) - 7'h08;
  endproperty
  property p_ack_level; IRQ_ACK && IRQ_REQ |=> !IRQ_REQ ##1 CPU_LEVEL == $past(IRQ_LEVEL, 2);
  endproperty
  property p_delayed_disable_instr; $rose(IRQ_REQ) && dis_left > 14'h0002 && dis_age == 2'h3 && IRQ_LEVEL < 4'h8
    |-> IRQ_LEVEL == 4'h7; endproperty
  property p_trap_go; TRAP_FLAG != 8'h00 && CPU_LEVEL < 4'h8 && !IRQ_ACK && !$past(IRQ_ACK)
    && !$past(IRQ_ACK, 2) |-> ##[0:3] (IRQ_REQ && IRQ_LEVEL >= 4'h8); endproperty
  property p_enabled; $rose(IRQ_REQ) && IRQ_LEVEL < 4'h8
    |-> |($past(SRC_ENABLE, 2) & (10'h001 << (IRQ_VECTOR - 7'h08))); endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  a_above: assert property (p_above) else $error("user request not above cpu");
  a_user_vec: assert property (p_user_vec) else $error("user vector out of range");
  a_trap_vec: assert property (p_trap_vec) else $error("trap vector wrong");
  a_ack_level: assert property (p_ack_level) else $error("cpu level after ack");
  a_delayed_disable_instr: assert property (p_delayed_disable_instr) else $error("request during disable");
  a_trap_go: assert property (p_trap_go) else $error("trap not delivered");
  a_enabled: assert property (p_enabled) else $error("disabled source requested");
  c_user_ack: cover property (IRQ_ACK && IRQ_REQ && IRQ_LEVEL < 4'h8);
  c_trap: cover property (IRQ_REQ && IRQ_LEVEL >= 4'h8);
  c_irq: cover property ($rose(IRQ));
endmodule
`default_nettype wire

// File: intprio_defines.vh
`ifndef INTPRIO_DEFINES_VH
`define INTPRIO_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets (word index on the register port)
// ----------------------------------------------------------------
`define OFS_PRIO14        4'h0
`define OFS_PRIO15        4'h1
`define OFS_PRIO16        4'h2
`define OFS_PRIO17        4'h3
`define OFS_PEND_STATUS   4'h4
`define OFS_CONTROL_ONE   4'h5
`define OFS_STATUS_LOW    4'h6
`define OFS_EVENT_STATUS  4'h7
`define OFS_EVENT_MASK    4'h8

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define NEST_DIS_BIT      15
`define IPL_HI            7
`define IPL_LO            5
`define LEVEL_HI          11
`define LEVEL_LO          8
`define VEC_HI            6
`define VEC_LO            0

// ----------------------------------------------------------------
// Implemented-field masks and reset values
// ----------------------------------------------------------------
`define MASK_PRIO14       16'h4007
`define MASK_PRIO14_FULL  16'h7007
`define MASK_PRIO15       16'h0077
`define MASK_PRIO16       16'h0770
`define MASK_PRIO17       16'h7777
`define PRIO_RESET_ALL    16'h4444
`define PRIO_DISABLED     3'h0
`define PRIO_TOP_USER     3'h7
`define PRIO_DELAYED_DISABLE_INSTR_MAX     3'h6

// ----------------------------------------------------------------
// Vector numbering, stack and counters
// ----------------------------------------------------------------
`define USER_VEC_BASE     7'h08
`define TRAP_LEVEL_BASE   4'h8
`define STACK_DEPTH       8
`define STACK_PTR_W       4
`define DELAYED_DISABLE_INSTR_CNT_W        14

`endif

// File: prio_reg.v
`default_nettype none

// ----------------------------------------------------------------
// One sixteen-bit priority register
// ----------------------------------------------------------------
module prio_reg #(
  parameter [15:0] FIELD_MASK = 16'h7777
) (
  input  wire        CLK,
  input  wire        RESET,
  input  wire        wr,
  input  wire [15:0] wdata,
  output reg  [15:0] q
);

`include "intprio_defines.vh"

  always @(posedge CLK) begin
    if (RESET) begin
      q <= `PRIO_RESET_ALL & FIELD_MASK;
    end else if (wr) begin
      q <= wdata & FIELD_MASK;
    end
  end

endmodule

`default_nettype wire
